// ==== src_pkg.sv ====
// Shared constants and types for the serial register command port
package src_pkg;

  // ************************************************************
  // Register file
  // ************************************************************
  localparam int NUM_REGS = 9;
  localparam int REG_W = 8;
  localparam int PTR_W = 5;
  localparam logic [8:0][7:0] REG_DEFAULTS = {
    8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h07, 8'h00, 8'h00, 8'h18};
  localparam logic [8:0][7:0] REG_WR_MASK = {
    8'h1f, 8'h1f, 8'hff, 8'hff, 8'hff, 8'hff, 8'hff, 8'hff, 8'h1f};
  localparam int ID_LSB = 5;

  // ************************************************************
  // Command encoding
  // ************************************************************
  localparam logic [3:0] OP_READ = 4'h2;
  localparam logic [3:0] OP_WRITE = 4'h4;
  localparam logic [3:0] OP_COUNT = 4'h0;
  localparam logic [6:0] OP_RESET = 7'h03;
  localparam logic [7:0] RESET_BYTE = 8'h06;
  localparam logic [4:0] FIRST_DATA_BYTE = 5'h02;

  // ************************************************************
  // Timing counts in master clock cycles
  // ************************************************************
  localparam int TIMEOUT_CYCLES_DEF = 2 ** 18;
  localparam int POR_CYCLES_DEF = 2 ** 16;
  localparam int PIN_HOLD_CYCLES = 2;
  localparam int SCLK_HALF_DEF = 8;

  // ************************************************************
  // Enumerations
  // ************************************************************
  typedef enum logic [1:0] {
    PH_OPCODE = 2'b00,
    PH_COUNT = 2'b01,
    PH_READ = 2'b10,
    PH_WRITE = 2'b11
  } src_phase_t;

  typedef enum logic [1:0] {
    HS_IDLE = 2'b00,
    HS_LOAD = 2'b01,
    HS_SHIFT = 2'b10,
    HS_GAP = 2'b11
  } src_hstate_t;

  typedef enum logic [1:0] {
    CMD_READ = 2'b00,
    CMD_WRITE = 2'b01,
    CMD_RESET = 2'b10
  } src_cmd_t;

endpackage

// ==== src_link_if.sv ====
// Four-wire serial link between host and device
`timescale 1ns/1ps
interface src_link_if;
  logic cs_n;
  logic sclk;
  logic din;
  logic dout;
  logic dout_oe_n;
  logic dout_line;

  // Undriven data line is pulled high
  assign dout_line = dout_oe_n ? 1'b1 : dout;

  modport dev (
    input cs_n,
    input sclk,
    input din,
    output dout,
    output dout_oe_n
  );

  modport host (
    output cs_n,
    output sclk,
    output din,
    input dout_line
  );
endinterface

// ==== src_device.sv ====
// Device end of the serial register command port
`timescale 1ns/1ps
module src_device #(
  parameter int TIMEOUT_CYCLES = src_pkg::TIMEOUT_CYCLES_DEF,
  parameter int POR_CYCLES = src_pkg::POR_CYCLES_DEF,
  parameter logic [2:0] ID_BITS = 3'h0 // Arbitrary identification value
) (
  input wire logic clk,
  input wire logic sys_rst,
  src_link_if.dev link,
  input wire logic reset_powerdown_pin_n,
  output logic [8:0][7:0] reg_image,
  output logic dev_ready
);

  // ************************************************************
  // State
  // ************************************************************
  localparam int TO_W = $clog2(TIMEOUT_CYCLES);
  localparam int HOLD_W = $clog2(POR_CYCLES) + 1;
  localparam logic [TO_W-1:0] TO_LAST = TO_W'(TIMEOUT_CYCLES - 1);
  localparam logic [HOLD_W-1:0] POR_LOAD = HOLD_W'(POR_CYCLES - 1);
  localparam logic [HOLD_W-1:0] PIN_LOAD =
    HOLD_W'(src_pkg::PIN_HOLD_CYCLES);
  localparam logic [8:0][7:0] DEFAULTS = {src_pkg::REG_DEFAULTS[8:1],
    ID_BITS, src_pkg::REG_DEFAULTS[0][src_pkg::ID_LSB-1:0]};

  typedef struct packed {
    logic [1:0] cs_s;
    logic [2:0] sclk_s;
    logic [1:0] din_s;
    logic [1:0] pin_s;
    logic [HOLD_W-1:0] hold_cnt;
    logic ready;
    logic [TO_W-1:0] to_cnt;
    src_pkg::src_phase_t phase;
    logic is_write;
    logic [2:0] bit_cnt;
    logic [7:0] rx;
    logic [7:0] tx;
    logic [src_pkg::PTR_W-1:0] ptr;
    logic [3:0] cnt;
    logic dout;
    logic dout_oe_n;
    logic [8:0][7:0] regs;
  } src_dev_state_t;

  localparam src_dev_state_t RESET_STATE = '{
    cs_s: 2'h3, sclk_s: 3'h0, din_s: 2'h0, pin_s: 2'h3,
    hold_cnt: POR_LOAD, ready: 1'b0, to_cnt: '0,
    phase: src_pkg::PH_OPCODE, is_write: 1'b0, bit_cnt: 3'h0,
    rx: 8'h00, tx: 8'h00, ptr: '0, cnt: 4'h0, dout: 1'b0,
    dout_oe_n: 1'b1, regs: DEFAULTS};

  src_dev_state_t q;
  src_dev_state_t n;

  // ************************************************************
  // Register read with out-of-range zero
  // ************************************************************
  function automatic logic [7:0] reg_read(
    input logic [8:0][7:0] r,
    input logic [src_pkg::PTR_W-1:0] a
  );
    logic [7:0] v;
    v = 8'h00;
    if (a < src_pkg::PTR_W'(src_pkg::NUM_REGS))
      v = r[a[3:0]];
    return v;
  endfunction

  // ************************************************************
  // Next state
  // ************************************************************
  logic rise;
  logic fall;
  logic to_hit;
  logic port_rst;
  logic [7:0] rx_byte;
  logic [7:0] rd_byte;

  always_comb
  begin
    n = q;
    n.cs_s = {q.cs_s[0], link.cs_n};
    n.sclk_s = {q.sclk_s[1:0], link.sclk};
    n.din_s = {q.din_s[0], link.din};
    n.pin_s = {q.pin_s[0], reset_powerdown_pin_n};
    rise = q.sclk_s[1] & ~q.sclk_s[2];
    fall = ~q.sclk_s[1] & q.sclk_s[2];
    rx_byte = {q.rx[6:0], q.din_s[1]};
    rd_byte = reg_read(q.regs, q.ptr);

    // Reset hold after pin release or power-on
    if (!q.pin_s[1])
    begin
      n.hold_cnt = PIN_LOAD;
      n.ready = 1'b0;
    end
    else if (q.hold_cnt != '0)
    begin
      n.hold_cnt = q.hold_cnt - HOLD_W'(1);
      n.ready = 1'b0;
    end
    else
      n.ready = 1'b1;
    if (!q.ready)
      n.regs = DEFAULTS;

    // Idle-low clock timeout
    to_hit = 1'b0;
    if (q.sclk_s[1])
      n.to_cnt = '0;
    else if (q.to_cnt == TO_LAST)
    begin
      n.to_cnt = '0;
      to_hit = 1'b1;
    end
    else
      n.to_cnt = q.to_cnt + TO_W'(1);

    // Output driven whenever selected and ready, including select tied low
    n.dout_oe_n = q.cs_s[1] | ~q.ready;

    port_rst = q.cs_s[1] | to_hit | ~q.ready;
    if (port_rst)
    begin
      n.phase = src_pkg::PH_OPCODE;
      n.bit_cnt = 3'h0;
      n.rx = 8'h00;
    end
    else if (rise)
    begin
      n.rx = rx_byte;
      n.bit_cnt = q.bit_cnt + 3'h1;
      if (q.bit_cnt == 3'h7)
      begin
        unique case (q.phase)
          src_pkg::PH_OPCODE:
          begin
            if (rx_byte[7:4] == src_pkg::OP_READ)
            begin
              n.is_write = 1'b0;
              n.ptr = {1'b0, rx_byte[3:0]};
              n.phase = src_pkg::PH_COUNT;
            end
            else if (rx_byte[7:4] == src_pkg::OP_WRITE)
            begin
              n.is_write = 1'b1;
              n.ptr = {1'b0, rx_byte[3:0]};
              n.phase = src_pkg::PH_COUNT;
            end
            else if (rx_byte[7:1] == src_pkg::OP_RESET)
              n.regs = DEFAULTS;
            // Anything else waits for the next byte boundary
          end
          src_pkg::PH_COUNT:
          begin
            if (rx_byte[7:4] == src_pkg::OP_COUNT)
            begin
              n.cnt = rx_byte[3:0];
              n.phase = q.is_write ? src_pkg::PH_WRITE
                                   : src_pkg::PH_READ;
            end
            else
              n.phase = src_pkg::PH_OPCODE;
          end
          src_pkg::PH_READ, src_pkg::PH_WRITE:
          begin
            if (q.phase == src_pkg::PH_WRITE &&
                q.ptr < src_pkg::PTR_W'(src_pkg::NUM_REGS))
              n.regs[q.ptr[3:0]] = (q.regs[q.ptr[3:0]] &
                ~src_pkg::REG_WR_MASK[q.ptr[3:0]]) | (rx_byte &
                src_pkg::REG_WR_MASK[q.ptr[3:0]]);
            if (q.ptr != '1)
              n.ptr = q.ptr + src_pkg::PTR_W'(1);
            if (q.cnt == 4'h0)
              n.phase = src_pkg::PH_OPCODE;
            else
              n.cnt = q.cnt - 4'h1;
          end
        endcase
      end
    end
    else if (fall && q.phase == src_pkg::PH_READ)
    begin
      if (q.bit_cnt == 3'h0)
      begin
        n.dout = rd_byte[7];
        n.tx = {rd_byte[6:0], 1'b0};
      end
      else
      begin
        n.dout = q.tx[7];
        n.tx = {q.tx[6:0], 1'b0};
      end
    end
  end

  // ************************************************************
  // Registers and outputs
  // ************************************************************
  always_ff @(posedge clk)
  begin
    if (sys_rst)
      q <= RESET_STATE;
    else
      q <= n;
  end

  assign link.dout = q.dout;
  assign link.dout_oe_n = q.dout_oe_n;
  assign reg_image = q.regs;
  assign dev_ready = q.ready;

endmodule // src_device

// ==== src_host.sv ====
// Host end of the serial register command port
`timescale 1ns/1ps
module src_host #(
  parameter int SCLK_HALF = src_pkg::SCLK_HALF_DEF
) (
  input wire logic clk,
  input wire logic sys_rst,
  src_link_if.host link,
  input wire logic cmd_valid,
  input wire logic [1:0] cmd_kind,
  input wire logic [3:0] cmd_addr,
  input wire logic [3:0] cmd_count,
  output logic cmd_ready,
  input wire logic [7:0] wr_data,
  input wire logic wr_valid,
  output logic wr_ready,
  output logic [7:0] rd_data,
  output logic rd_valid
);

  // ************************************************************
  // State
  // ************************************************************
  localparam int DIV_W = $clog2(SCLK_HALF + 1);
  localparam logic [DIV_W-1:0] DIV_LAST = DIV_W'(SCLK_HALF - 1);

  typedef struct packed {
    src_pkg::src_hstate_t st;
    logic cs_n;
    logic sclk;
    logic din;
    logic [1:0] dout_s;
    logic [DIV_W-1:0] div;
    logic [2:0] bit_cnt;
    logic [4:0] byte_idx;
    logic [4:0] last_idx;
    logic [1:0] kind;
    logic [3:0] addr;
    logic [3:0] count;
    logic [7:0] tx;
    logic [7:0] rx;
    logic cmd_ready;
    logic wr_ready;
    logic [7:0] rd_data;
    logic rd_valid;
  } src_host_state_t;

  localparam src_host_state_t RESET_STATE = '{
    st: src_pkg::HS_IDLE, cs_n: 1'b1, sclk: 1'b0, din: 1'b0,
    dout_s: 2'h0, div: '0, bit_cnt: 3'h0, byte_idx: 5'h00,
    last_idx: 5'h00, kind: 2'h0, addr: 4'h0, count: 4'h0, tx: 8'h00,
    rx: 8'h00, cmd_ready: 1'b1, wr_ready: 1'b0, rd_data: 8'h00,
    rd_valid: 1'b0};

  src_host_state_t q;
  src_host_state_t n;
  logic [7:0] nxt_byte;
  logic have_byte;

  // ************************************************************
  // Next state
  // ************************************************************
  always_comb
  begin
    n = q;
    n.dout_s = {q.dout_s[0], link.dout_line};
    n.wr_ready = 1'b0;
    n.rd_valid = 1'b0;
    nxt_byte = 8'h00;
    have_byte = 1'b1;
    if (q.byte_idx == 5'h00)
      nxt_byte = (q.kind == src_pkg::CMD_RESET) ? src_pkg::RESET_BYTE
        : {(q.kind == src_pkg::CMD_WRITE) ? src_pkg::OP_WRITE
        : src_pkg::OP_READ, q.addr};
    else if (q.byte_idx == 5'h01)
      nxt_byte = {src_pkg::OP_COUNT, q.count};
    else if (q.kind == src_pkg::CMD_WRITE)
    begin
      nxt_byte = wr_data;
      have_byte = wr_valid;
    end
    unique case (q.st)
      src_pkg::HS_IDLE:
      begin
        if (cmd_valid)
        begin
          n.kind = cmd_kind;
          n.addr = cmd_addr;
          n.count = cmd_count;
          n.last_idx = (cmd_kind == src_pkg::CMD_RESET) ? 5'h00
            : {1'b0, cmd_count} + src_pkg::FIRST_DATA_BYTE;
          n.byte_idx = 5'h00;
          n.cmd_ready = 1'b0;
          n.st = src_pkg::HS_LOAD;
        end
      end
      src_pkg::HS_LOAD:
      begin
        n.cs_n = 1'b0;
        if (have_byte)
        begin
          n.wr_ready = (q.kind == src_pkg::CMD_WRITE) &&
            (q.byte_idx >= src_pkg::FIRST_DATA_BYTE);
          n.din = nxt_byte[7];
          n.tx = {nxt_byte[6:0], 1'b0};
          n.bit_cnt = 3'h0;
          n.div = '0;
          n.st = src_pkg::HS_SHIFT;
        end
      end
      src_pkg::HS_SHIFT:
      begin
        n.div = q.div + DIV_W'(1);
        if (q.div == DIV_LAST)
        begin
          n.div = '0;
          n.sclk = ~q.sclk;
          if (!q.sclk)
            n.rx = {q.rx[6:0], q.dout_s[1]};
          else if (q.bit_cnt == 3'h7)
          begin
            if (q.kind == src_pkg::CMD_READ &&
                q.byte_idx >= src_pkg::FIRST_DATA_BYTE)
            begin
              n.rd_data = q.rx;
              n.rd_valid = 1'b1;
            end
            n.byte_idx = q.byte_idx + 5'h01;
            if (q.byte_idx == q.last_idx)
            begin
              n.cs_n = 1'b1;
              n.st = src_pkg::HS_GAP;
            end
            else
              n.st = src_pkg::HS_LOAD;
          end
          else
          begin
            n.bit_cnt = q.bit_cnt + 3'h1;
            n.din = q.tx[7];
            n.tx = {q.tx[6:0], 1'b0};
          end
        end
      end
      src_pkg::HS_GAP:
      begin
        n.div = q.div + DIV_W'(1);
        if (q.div == DIV_LAST)
        begin
          n.div = '0;
          n.cmd_ready = 1'b1;
          n.st = src_pkg::HS_IDLE;
        end
      end
    endcase
  end

  // ************************************************************
  // Registers and outputs
  // ************************************************************
  always_ff @(posedge clk)
  begin
    if (sys_rst)
      q <= RESET_STATE;
    else
      q <= n;
  end

  assign link.cs_n = q.cs_n;
  assign link.sclk = q.sclk;
  assign link.din = q.din;
  assign cmd_ready = q.cmd_ready;
  assign wr_ready = q.wr_ready;
  assign rd_data = q.rd_data;
  assign rd_valid = q.rd_valid;

endmodule // src_host

// ==== src_monitor.sv ====
// Link checker for the serial register command port
`timescale 1ns/1ps
module src_monitor (
  input wire logic clk,
  input wire logic sys_rst,
  input wire logic cs_n,
  input wire logic sclk,
  input wire logic din,
  input wire logic dout,
  input wire logic dout_oe_n,
  input wire logic dout_line
);
  // ****
  // Rising clock edges within a frame
  // ****
  logic [7:0] rise_cnt_ff;
  logic sclk_ff;

  always_ff @(posedge clk)
  begin
    sclk_ff <= sclk;
    if (sys_rst || cs_n)
      rise_cnt_ff <= 8'h00;
    else if (sclk && !sclk_ff)
      rise_cnt_ff <= rise_cnt_ff + 8'h01;
  end

  default clocking @(posedge clk); endclocking
  default disable iff (sys_rst);

  // ****
  // Link properties
  // ****
  sel_drive_a: assert property (!cs_n [*4] |-> !dout_oe_n)
    else $error("data output not driven while selected");
  sel_release_a: assert property (cs_n [*4] |-> dout_oe_n)
    else $error("data output driven while deselected");
  line_idle_a: assert property (dout_oe_n |-> dout_line)
    else $error("released data line not high");
  out_edge_a: assert property (
    !dout_oe_n && $changed(dout) |-> !sclk &&
    ($past(sclk, 3) || $past(sclk, 4) || $past(sclk, 5) || $past(sclk, 6)))
    else $error("data output moved away from a falling edge");
  in_edge_a: assert property (!cs_n && $changed(din) |-> !sclk)
    else $error("data input moved while clock high");
  low_phase_a: assert property ($fell(sclk) |-> !sclk [*4])
    else $error("clock low phase too short");
  high_phase_a: assert property ($rose(sclk) |-> sclk [*4])
    else $error("clock high phase too short");
  cmd_quiet_a: assert property (!cs_n && $changed(dout) |->
    rise_cnt_ff >= 8'h10)
    else $error("data output moved during command bytes");
  whole_byte_a: assert property (
    $rose(cs_n) |-> rise_cnt_ff[2:0] == 3'h0)
    else $error("frame closed off a byte boundary");
  sel_frame_a: assert property (
    $changed(sclk) |-> !cs_n || !$past(cs_n))
    else $error("clock toggled while deselected");
endmodule // src_monitor

// ==== serial_register_command_port_bench.sv ====
// Testbench for the serial register command port
`timescale 1ns/1ps
`define CHK(nm, e, g) begin num_checks++; if ((g) !== (e)) begin \
  n_fail++; $display("ERROR %s expected %h seen %h", nm, e, g); end end
module serial_register_command_port_bench;
  localparam int POR = 16;
  logic clk, sys_rst, pin_b_n, cmd_valid, cmd_ready, wr_valid, wr_ready;
  logic rd_valid, dev_ready, dev_ready_b;
  logic [1:0] cmd_kind;
  logic [3:0] cmd_addr, cmd_count;
  logic [7:0] wr_data, rd_data;
  logic [8:0][7:0] img, img_b, ea, eb;
  logic [7:0] wbuf [0:15];
  logic [7:0] rq [$];
  int widx, n_fail, num_checks;

  src_link_if la ();
  src_link_if lb ();
  src_device #(.TIMEOUT_CYCLES(256), .POR_CYCLES(POR)) u_src_device (
    .clk(clk), .sys_rst(sys_rst), .link(la.dev),
    .reset_powerdown_pin_n(1'b1), .reg_image(img), .dev_ready(dev_ready));
  src_host u_src_host (.clk(clk), .sys_rst(sys_rst), .link(la.host),
    .cmd_valid(cmd_valid), .cmd_kind(cmd_kind), .cmd_addr(cmd_addr),
    .cmd_count(cmd_count), .cmd_ready(cmd_ready), .wr_data(wr_data),
    .wr_valid(wr_valid), .wr_ready(wr_ready), .rd_data(rd_data),
    .rd_valid(rd_valid));
  src_device #(.TIMEOUT_CYCLES(64), .POR_CYCLES(POR)) u_src_device_b (
    .clk(clk), .sys_rst(sys_rst), .link(lb.dev),
    .reset_powerdown_pin_n(pin_b_n), .reg_image(img_b),
    .dev_ready(dev_ready_b));
  src_monitor u_src_monitor (.clk(clk), .sys_rst(sys_rst), .cs_n(la.cs_n),
    .sclk(la.sclk), .din(la.din), .dout(la.dout),
    .dout_oe_n(la.dout_oe_n), .dout_line(la.dout_line));

  assign wr_data = wbuf[widx];
  always @(posedge clk) if (wr_ready === 1'b1) #1 widx++;
  always @(posedge clk) if (rd_valid === 1'b1) rq.push_back(rd_data);

  initial
  begin
    clk = 1'b0;
    forever #20 clk = ~clk;
  end

  // ****
  // Closing and host access tasks
  // ****
  task end_sim;
    if (n_fail == 0 && num_checks > 0)
      $display("TB: PASS");
    else
      $display("TB: FAIL");
    $finish;
  endtask

  task hcmd(input logic [1:0] k, input logic [3:0] a, input logic [3:0] n);
    int t;
    @(posedge clk);
    #1;
    cmd_kind = k;
    cmd_addr = a;
    cmd_count = n;
    cmd_valid = 1'b1;
    @(posedge clk);
    #1;
    cmd_valid = 1'b0;
    t = 0;
    repeat (2) @(posedge clk);
    while (cmd_ready !== 1'b1 && t < 9000)
    begin
      @(posedge clk);
      t++;
    end
    `CHK("cmd_done", 1'b1, cmd_ready)
  endtask

  task rdchk(input logic [3:0] a, input logic [3:0] n);
    rq.delete();
    hcmd(2'h0, a, n);
    `CHK("rd_count", n + 5'h01, 5'(rq.size()))
    for (int i = 0; i <= n; i++)
      `CHK("rd_data", (a + i < 9) ? ea[a + i] : 8'h00, rq[i])
  endtask

  task wr(input logic [3:0] a, input logic [3:0] n);
    widx = 0;
    wr_valid = 1'b0;
    fork
      hcmd(2'h1, a, n);
      begin
        repeat (300) @(posedge clk);
        #1;
        wr_valid = 1'b1;
      end
    join
    wr_valid = 1'b0;
    for (int i = 0; i <= n; i++)
      if (a + i < 9)
        ea[a + i] = (ea[a + i] & ~src_pkg::REG_WR_MASK[a + i]) |
          (wbuf[i] & src_pkg::REG_WR_MASK[a + i]);
    `CHK("image", ea, img)
  endtask

  // ****
  // Direct link tasks for the second device
  // ****
  task xb(input logic [7:0] b);
    for (int i = 7; i >= 0; i--)
    begin
      lb.din = b[i];
      repeat (4) @(posedge clk);
      #1;
      lb.sclk = 1'b1;
      repeat (4) @(posedge clk);
      #1;
      lb.sclk = 1'b0;
    end
  endtask

  task wrb(input logic [3:0] a, input logic [7:0] d);
    xb({4'h4, a});
    xb(8'h00);
    xb(d);
    repeat (8) @(posedge clk);
    #1;
  endtask

  task stray;
    lb.sclk = 1'b1;
    repeat (4) @(posedge clk);
    #1;
    lb.sclk = 1'b0;
    repeat (4) @(posedge clk);
    #1;
  endtask

  initial
  begin
    #1000000;
    n_fail++;
    end_sim;
  end

  // ****
  // Test sequence
  // ****
  initial
  begin
    sys_rst = 1'b1;
    pin_b_n = 1'b1;
    cmd_valid = 1'b0;
    cmd_kind = 2'h0;
    cmd_addr = 4'h0;
    cmd_count = 4'h0;
    wr_valid = 1'b0;
    widx = 0;
    n_fail = 0;
    num_checks = 0;
    lb.cs_n = 1'b0;
    lb.sclk = 1'b0;
    lb.din = 1'b0;
    ea = src_pkg::REG_DEFAULTS;
    eb = src_pkg::REG_DEFAULTS;
    repeat (3) @(posedge clk);
    #1;
    sys_rst = 1'b0;
    repeat (POR - 1) @(posedge clk);
    #1;
    `CHK("por_hold", 1'b0, dev_ready)
    repeat (4) @(posedge clk);
    #1;
    `CHK("por_ready", 1'b1, dev_ready)
    `CHK("por_image", ea, img)
    `CHK("tied_drive", 1'b0, lb.dout_oe_n)
    rdchk(4'h0, 4'h8);
    wbuf[0] = 8'ha5;
    wbuf[1] = 8'h5a;
    wbuf[2] = 8'hff;
    wbuf[3] = 8'h11;
    wr(4'h7, 4'h3);
    rdchk(4'h6, 4'h4);
    hcmd(2'h2, 4'h0, 4'h0);
    ea = src_pkg::REG_DEFAULTS;
    `CHK("cmd_reset", ea, img)
    wrb(4'h1, 8'h3c);
    eb[1] = 8'h3c;
    `CHK("tied_write", eb, img_b)
    lb.din = 1'b0;
    stray;
    repeat (80) @(posedge clk);
    #1;
    wrb(4'h2, 8'h77);
    eb[2] = 8'h77;
    `CHK("timeout", eb, img_b)
    stray;
    lb.sclk = 1'b1;
    repeat (200) @(posedge clk);
    #1;
    lb.sclk = 1'b0;
    wrb(4'h2, 8'h99);
    `CHK("high_idle", eb, img_b)
    lb.din = 1'b0;
    repeat (80) @(posedge clk);
    #1;
    xb(8'h80);
    wrb(4'h3, 8'h5a);
    eb[3] = 8'h5a;
    `CHK("unknown_op", eb, img_b)
    xb(8'h07);
    repeat (8) @(posedge clk);
    #1;
    eb = src_pkg::REG_DEFAULTS;
    `CHK("reset_07", eb, img_b)
    lb.din = 1'b1;
    repeat (4) stray;
    lb.cs_n = 1'b1;
    repeat (8) @(posedge clk);
    #1;
    `CHK("desel_oe", 1'b1, lb.dout_oe_n)
    lb.cs_n = 1'b0;
    repeat (4) @(posedge clk);
    #1;
    wrb(4'h4, 8'hc3);
    eb[4] = 8'hc3;
    `CHK("desel_reset", eb, img_b)
    pin_b_n = 1'b0;
    repeat (5) @(posedge clk);
    #1;
    `CHK("pin_ready", 1'b0, dev_ready_b)
    `CHK("pin_image", src_pkg::REG_DEFAULTS, img_b)
    pin_b_n = 1'b1;
    repeat (2) @(posedge clk);
    #1;
    `CHK("pin_hold", 1'b0, dev_ready_b)
    repeat (8) @(posedge clk);
    #1;
    `CHK("pin_release", 1'b1, dev_ready_b)
    end_sim;
  end
endmodule // serial_register_command_port_bench
